// ---- tb.sv ----
`timescale 1ns/100ps

module tb;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ac, as, ab, dc, ds, db, pg, er, dso, busy;
  int          miscompares = 0;
  int          compares = 0;
  int          n;
  logic [15:0] w;

  // Clock
  always #12.5 sys_clk_in = ~sys_clk_in;

  ufmsa_top uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .addr_shift_clock_in(ac), .addr_shift_select_in(as),
    .addr_serial_in(ab), .data_shift_clock_in(dc),
    .data_shift_select_in(ds), .data_serial_in(db), .program_in(pg),
    .erase_in(er), .data_serial_out(dso), .busy_out(busy));
  ufmsa_user_model usr (.clk_in(sys_clk_in), .busy_in(busy),
    .dso_in(dso), .aclk_out(ac), .asel_out(as), .abit_out(ab),
    .dclk_out(dc), .dsel_out(ds), .dbit_out(db), .prog_out(pg),
    .erase_out(er));

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : check

  task automatic wrap_up;
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic do_op(input logic e, input int lo);
    usr.run_op(e, n);
    check("busy len", 16'h0001, {15'h0000, n >= lo && n <= lo + 4});
    if (n >= 500) wrap_up();
  endtask : do_op

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    usr.send_addr(a);
    usr.send_data(d);
    do_op(1'b0, 37);
  endtask : wr

  task automatic t_reset;
    @(posedge sys_clk_in);
    #1;
    check("idle", 16'h0000, {14'h0000, busy, dso});
  endtask : t_reset

  task automatic t_sectors;
    usr.send_addr(9'h000);
    do_op(1'b1, 397);
    usr.send_addr(9'h1FF);
    do_op(1'b1, 397);
    wr(9'h0FF, 16'h1357);
    wr(9'h100, 16'hC0DE);
    usr.send_addr(9'h000);
    do_op(1'b1, 397);
    usr.send_addr(9'h0FF);
    usr.read_word(w);
    check("erased", 16'hFFFF, w);
  endtask : t_sectors

  task automatic t_stream;
    usr.strobe(1'b1, 1'b0, 1'b0);
    usr.read_word(w);
    check("next word", 16'hC0DE, w);
  endtask : t_stream

  task automatic t_busy;
    usr.send_addr(9'h1FF);
    usr.send_data(16'h0F0F);
    fork
      do_op(1'b1, 397);
      begin
        repeat (4) @(posedge sys_clk_in);
        usr.send_addr(9'h000);
        usr.send_data(16'h0000);
      end
    join
    do_op(1'b0, 37);
    usr.read_word(w);
    check("ignored shift", 16'h0F0F, w);
    usr.send_addr(9'h100);
    usr.read_word(w);
    check("sector1 erased", 16'hFFFF, w);
  endtask : t_busy

  task automatic t_reset2;
    usr.send_data(16'h8001);
    check("dso before reset", 16'h0001, {15'h0000, dso});
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    check("idle again", 16'h0000, {14'h0000, busy, dso});
    do_op(1'b0, 37);
    usr.read_word(w);
    check("word at reset addr", 16'h0000, w);
    usr.send_addr(9'h1FF);
    usr.read_word(w);
    check("kept over reset", 16'h0F0F, w);
  endtask : t_reset2

  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_sectors();
    t_stream();
    t_busy();
    t_reset2();
    wrap_up();
  end
endmodule : tb

// ---- ufmsa_pkg.sv ----
package ufmsa_pkg;

  // ******************************************************
  // Array geometry
  // ******************************************************
  localparam int              ADDR_W       = 9;
  localparam int              DATA_W       = 16;
  localparam int              WORDS        = 512;
  localparam int              TOTAL_BITS   = 8192;
  localparam int              SECTOR_BITS  = 4096;
  localparam int              SECTOR_BIT   = 8;
  localparam logic [8:0]      ADDR_FIRST   = 9'h000;
  localparam logic [8:0]      ADDR_LAST    = 9'h1FF;
  localparam logic [8:0]      SEC0_LAST    = 9'h0FF;
  localparam logic [8:0]      SEC1_FIRST   = 9'h100;
  localparam logic [15:0]     ERASED_WORD  = 16'hFFFF;
  localparam logic [8:0]      ADDR_RST     = 9'h000;
  localparam logic [15:0]     DATA_RST     = 16'h0000;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int              CLK_PERIOD_NS = 25;
  localparam int              PROG_TIME_NS  = 1000;
  localparam int              ERASE_TIME_NS = 10000;
  localparam int              PROG_CYC      =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int              ERASE_CYC     =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int              CNT_W         = 12;

  // ******************************************************
  // Operation states
  // ******************************************************
  typedef enum logic [1:0] {
    UFMSA_IDLE  = 2'b00,
    UFMSA_PROG  = 2'b01,
    UFMSA_ERASE = 2'b10
  } ufmsa_state_t;

endpackage : ufmsa_pkg

// ---- ufmsa_store.sv ----
`timescale 1ns/100ps

module ufmsa_store (
  input  wire logic        sys_clk_in,
  input  wire logic        wr_en_in,
  input  wire logic        erase_en_in,
  input  wire logic [8:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);

  // ******************************************************
  // Word storage, never reset: contents survive reset
  // ******************************************************
  // R2: 512 words, 9-bit index
  // R3: 16-bit word width
  logic [15:0] mem [ufmsa_pkg::WORDS];

  // Sector number of an address
  function automatic logic sector_of(input logic [8:0] a);
    sector_of = a[ufmsa_pkg::SECTOR_BIT];
  endfunction : sector_of

  // Per-word update: sector erase or bitwise program
  for (genvar g = 0; g < ufmsa_pkg::WORDS; g++) begin : g_word
    localparam logic [8:0] IDX = 9'(g);
    // R5: one sector only
    // R7: other sector kept
    always_ff @(posedge sys_clk_in) begin
      if (erase_en_in && sector_of(addr_in) == sector_of(IDX)) begin
        mem[g] <= ufmsa_pkg::ERASED_WORD;
      end else if (wr_en_in && addr_in == IDX) begin
        mem[g] <= mem[g] & wdata_in;  // Program only clears bits
      end
    end
  end

  // Word read by index
  assign rdata_out = mem[addr_in];

endmodule : ufmsa_store

// ---- ufmsa_top.sv ----
`timescale 1ns/100ps

// Summary of operation
// R1: The array holds 8,192 bits that are never cleared by reset.
// R2: There are 512 words addressed by 9 bits, 000h to 1FFh.
// R3: Each word is 16 bits; narrower widths are built outside.
// R4: Words 000h-0FFh form sector 0 and 100h-1FFh sector 1, 4,096 bits each.
// R5: An erase clears only the sector that the address register selects.
// R6: User logic erases a sector before programming words inside it.
// R7: Erasing or programming one sector leaves the other untouched.
// R8: Clock and controls arrive from the column clock lines.
// R9: Any outward protocol is built by user logic, not by this block.
// R10: User logic holds program or erase high until busy falls.
// R11: An address clock with shift select low increments the address.
// R12: Address shift register is 9 bits and data shift register 16 bits.
// R13: While busy, new program, erase, shift and read requests are ignored.
module ufmsa_top (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic addr_shift_clock_in,
  input  wire logic addr_shift_select_in,
  input  wire logic addr_serial_in,
  input  wire logic data_shift_clock_in,
  input  wire logic data_shift_select_in,
  input  wire logic data_serial_in,
  input  wire logic program_in,
  input  wire logic erase_in,
  output logic      data_serial_out,
  output logic      busy_out
);

  // ******************************************************
  // Declarations
  // ******************************************************
  logic [8:0]                 addr_r;
  logic [15:0]                data_r;
  logic [15:0]                rdata;
  logic [3:0]                 strobe;
  logic [3:0]                 strobe_d_r;
  logic [3:0]                 strobe_rise;
  logic                       take_erase;
  logic                       take_prog;
  logic                       store_wr;
  logic                       store_erase;
  logic [ufmsa_pkg::CNT_W-1:0] cnt_r;
  ufmsa_pkg::ufmsa_state_t    state_r;
  ufmsa_pkg::ufmsa_state_t    state_nxt;
  logic                       aclk_rise;
  logic                       dclk_rise;
  logic                       prog_rise;
  logic                       erase_rise;
  logic                       idle;
  logic                       done;

  localparam logic [ufmsa_pkg::CNT_W-1:0] PROG_LOAD =
    ufmsa_pkg::CNT_W'(ufmsa_pkg::PROG_CYC - 1);
  localparam logic [ufmsa_pkg::CNT_W-1:0] ERASE_LOAD =
    ufmsa_pkg::CNT_W'(ufmsa_pkg::ERASE_CYC - 1);
  localparam logic [ufmsa_pkg::CNT_W-1:0] CNT_ZERO = '0;

  // Bit of each strobe in the edge detector
  localparam int              STB_ACLK  = 0;
  localparam int              STB_DCLK  = 1;
  localparam int              STB_PROG  = 2;
  localparam int              STB_ERASE = 3;
  localparam int              STB_N     = 4;

  // Operation of a given kind reaching its last cycle
  function automatic logic op_ends(
    input ufmsa_pkg::ufmsa_state_t st,
    input ufmsa_pkg::ufmsa_state_t kind,
    input logic                    fin
  );
    op_ends = fin && (st == kind);
  endfunction : op_ends

  // ******************************************************
  // Strobe edge detection
  // ******************************************************

  // Strobes gathered for one detector per bit
  assign strobe[STB_ACLK]  = addr_shift_clock_in;
  assign strobe[STB_DCLK]  = data_shift_clock_in;
  assign strobe[STB_PROG]  = program_in;
  assign strobe[STB_ERASE] = erase_in;

  // R8: controls sampled on the column clock
  for (genvar s = 0; s < STB_N; s++) begin : g_strobe
    // Previous level, low after reset like an idle strobe
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        strobe_d_r[s] <= 1'b0;
      end else begin
        strobe_d_r[s] <= strobe[s];
      end
    end
  end

  // Rising edges of the user strobes
  assign strobe_rise = strobe & ~strobe_d_r;
  assign aclk_rise   = strobe_rise[STB_ACLK];
  assign dclk_rise   = strobe_rise[STB_DCLK];
  assign prog_rise   = strobe_rise[STB_PROG];
  assign erase_rise  = strobe_rise[STB_ERASE];
  assign idle        = (state_r == ufmsa_pkg::UFMSA_IDLE);
  assign done        = ~idle & (cnt_r == CNT_ZERO);

  // R13: requests taken only while idle, erase wins a tie
  assign take_erase  = idle & erase_rise;
  assign take_prog   = idle & prog_rise & ~erase_rise;

  // ******************************************************
  // Operation sequencer
  // ******************************************************

  // Next operation state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ufmsa_pkg::UFMSA_IDLE: begin
        // R10: start on request edge, held until busy falls
        if (erase_rise) begin
          state_nxt = ufmsa_pkg::UFMSA_ERASE;
        end else if (prog_rise) begin
          state_nxt = ufmsa_pkg::UFMSA_PROG;
        end
      end
      ufmsa_pkg::UFMSA_PROG,
      ufmsa_pkg::UFMSA_ERASE: begin
        if (done) begin
          state_nxt = ufmsa_pkg::UFMSA_IDLE;
        end
      end
      default: begin
        state_nxt = ufmsa_pkg::UFMSA_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= ufmsa_pkg::UFMSA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Operation timer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_r <= CNT_ZERO;
    end else if (take_erase) begin
      cnt_r <= ERASE_LOAD;
    end else if (take_prog) begin
      cnt_r <= PROG_LOAD;
    end else if (!idle && cnt_r != CNT_ZERO) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // ******************************************************
  // Status
  // ******************************************************

  // R13: busy for whole operation
  assign busy_out = ~idle;

  // ******************************************************
  // Serial address and data registers
  // ******************************************************

  // R12: 9-bit address shifter
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      addr_r <= ufmsa_pkg::ADDR_RST;
    // R13: ignored while busy
    end else if (idle && aclk_rise) begin
      if (addr_shift_select_in) begin
        addr_r <= {addr_r[7:0], addr_serial_in};
      end else begin
        // R11: auto-increment on clock
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // R12: 16-bit data shifter, load from array when select low
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      data_r <= ufmsa_pkg::DATA_RST;
    end else if (idle && dclk_rise) begin
      if (data_shift_select_in) begin
        data_r <= {data_r[14:0], data_serial_in};
      end else begin
        data_r <= rdata;
      end
    end
  end

  // Serial data out, most significant bit first
  assign data_serial_out = data_r[15];

  // ******************************************************
  // Flash array
  // ******************************************************

  // Array strobes on the last cycle of an operation
  assign store_wr    = op_ends(state_r, ufmsa_pkg::UFMSA_PROG, done);
  assign store_erase = op_ends(state_r, ufmsa_pkg::UFMSA_ERASE, done);

  // R1: nonvolatile words, R4: sector split by address
  ufmsa_store u_store (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (store_wr),
    .erase_en_in (store_erase),
    .addr_in     (addr_r),
    .wdata_in    (data_r),
    .rdata_out   (rdata)
  );

endmodule : ufmsa_top

// ---- ufmsa_top_monitor.sv ----
`timescale 1ns/100ps

// ****
// Port checker
// ****
module ufmsa_top_chk (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic data_shift_clock_in,
  input wire logic program_in,
  input wire logic erase_in,
  input wire logic data_serial_out,
  input wire logic busy_out
);
  logic [9:0] blen_r;

  // Busy run length
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !busy_out) blen_r <= 10'h000;
    else blen_r <= blen_r + 10'h001;
  end

  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_reset_quiet: assert property (
    disable iff (1'b0) rst_in |=> !busy_out && !data_serial_out)
    else $error("outputs not idle after reset");
  a_op_take: assert property (
    ($rose(program_in) || $rose(erase_in)) && !busy_out |=> busy_out)
    else $error("request not taken");
  a_op_cause: assert property (
    $rose(busy_out) |-> $past(program_in) || $past(erase_in))
    else $error("busy without request");
  a_busy_freeze: assert property (
    busy_out |=> $stable(data_serial_out))
    else $error("shift taken while busy");
  a_dso_stands: assert property (
    !$rose(data_shift_clock_in) |=> $stable(data_serial_out))
    else $error("serial out moved without strobe");
  a_prog_time: assert property (
    $rose(program_in) && !erase_in && !busy_out
      |=> ##[30:41] $fell(busy_out))
    else $error("program length wrong");
  a_erase_time: assert property (
    $rose(erase_in) && !busy_out |=> ##[390:402] $fell(busy_out))
    else $error("erase length wrong");
  a_op_length: assert property (
    $fell(busy_out) |-> (blen_r > 10'h025 && blen_r < 10'h02A) ||
      (blen_r > 10'h18D && blen_r < 10'h192))
    else $error("busy run length wrong");
endmodule : ufmsa_top_chk

bind ufmsa_top ufmsa_top_chk chk (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .data_shift_clock_in(data_shift_clock_in),
  .program_in(program_in),
  .erase_in(erase_in),
  .data_serial_out(data_serial_out),
  .busy_out(busy_out)
);

// ---- ufmsa_user_model.sv ----
`timescale 1ns/100ps

// ****
// Far-side user logic
// ****
// outward access built here
module ufmsa_user_model (
  input  wire logic clk_in,
  input  wire logic busy_in,
  input  wire logic dso_in,
  output logic      aclk_out,
  output logic      asel_out,
  output logic      abit_out,
  output logic      dclk_out,
  output logic      dsel_out,
  output logic      dbit_out,
  output logic      prog_out,
  output logic      erase_out
);
  // Only strobes and requests start low; bits follow each strobe
  initial begin
    {aclk_out, dclk_out, prog_out, erase_out} = 4'h0;
  end

  // One strobe rise, held to its edge
  task automatic strobe(input logic on_a, input logic sel, input logic b);
    @(posedge clk_in);
    if (on_a) begin
      asel_out <= sel;
      abit_out <= b;
      aclk_out <= 1'b1;
    end else begin
      dsel_out <= sel;
      dbit_out <= b;
      dclk_out <= 1'b1;
    end
    @(posedge clk_in);
    aclk_out <= 1'b0;
    dclk_out <= 1'b0;
    abit_out <= ~abit_out;
    dbit_out <= ~dbit_out;
    #1;
  endtask : strobe

  task automatic send_addr(input logic [8:0] a);
    for (int i = 8; i >= 0; i--) strobe(1'b1, 1'b1, a[i]);
  endtask : send_addr

  task automatic send_data(input logic [15:0] d);
    for (int i = 15; i >= 0; i--) strobe(1'b0, 1'b1, d[i]);
  endtask : send_data

  task automatic read_word(output logic [15:0] w);
    strobe(1'b0, 1'b0, 1'b0);
    w[15] = dso_in;
    for (int i = 14; i >= 0; i--) begin
      strobe(1'b0, 1'b1, 1'b0);
      w[i] = dso_in;
    end
  endtask : read_word

  task automatic run_op(input logic er, output int n);
    @(posedge clk_in);
    prog_out <= !er;
    erase_out <= er;
    n = 0;
    @(posedge clk_in);
    #1;
    while (busy_in && n < 500) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    @(posedge clk_in);
    prog_out <= 1'b0;
    erase_out <= 1'b0;
  endtask : run_op
endmodule : ufmsa_user_model
